// ==== design/bmc_map.svh ====
// Purpose: Register offsets, limits and reset values of the burst controller.
// Assumes: Frequencies in 0.01 Hz units, phase in millidegrees.
// Notes: Definitions only.
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH
`define BMC_CLK_HZ 32'd25000000
`define BMC_CU_PER_HZ 32'd100
`define BMC_NCO_MOD (`BMC_CLK_HZ * `BMC_CU_PER_HZ)
`define BMC_A_CTRL 8'h00
`define BMC_A_FREQ 8'h04
`define BMC_A_COUNT 8'h08
`define BMC_A_RATE 8'h0C
`define BMC_A_PHASE 8'h10
`define BMC_A_POINTS 8'h14
`define BMC_A_STATUS 8'h18
`define BMC_A_ERR 8'h1C
`define BMC_A_TRIG 8'h20
`define BMC_CTRL_W 15
`define BMC_NBP 8
`define BMC_F_MIN 32'd1
`define BMC_F_MIN_ARB 32'd10
`define BMC_F_MAX 32'd500000000
`define BMC_F_MAX_TRI 32'd10000000
`define BMC_F_ARB_MID 32'd250000000
`define BMC_F_ARB_LOW 32'd20000000
`define BMC_PTS_8K 32'd8192
`define BMC_PTS_12K 32'd12287
`define BMC_PTS_RST 32'd8
`define BMC_F_STEP 32'd100000000
`define BMC_MINCNT_TOP 5
`define BMC_F_LOWBAND 32'd10000
`define BMC_MAX_SECS 32'd500
`define BMC_F_RST 32'd100000
`define BMC_CNT_INF 32'd0
`define BMC_CNT_MIN 32'd1
`define BMC_CNT_MAX 32'd50000
`define BMC_R_MIN 32'd1
`define BMC_R_MAX 32'd5000000
`define BMC_R_RST 32'd10000
`define BMC_PH_MAX 32'sd360000
`define BMC_ERR_CODE 32'hFFFFFF23
`endif

// ==== design/bmc_nco.sv ====
// Purpose: Modulo accumulator giving carrier phase and rate timer ticks.
// Assumes: i_inc below i_mod.
// Notes: o_wrap pulses in the cycle where o_acc holds the wrapped value.
`timescale 1ns/100ps
module bmc_nco #(
  parameter int W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_restart,
  input wire logic [W-1:0] i_inc,
  input wire logic [W-1:0] i_mod,
  output logic [W-1:0] o_acc,
  output logic o_wrap
);
  logic [W-1:0] acc_q, acc_d;
  logic wrap_q, wrap_d;
  logic [W:0] sum;

  always_comb begin
    sum = {1'b0, acc_q} + {1'b0, i_inc};
    acc_d = sum[W-1:0];
    wrap_d = 1'b0;
    if (i_restart) begin
      acc_d = '0;
    end else if (sum >= {1'b0, i_mod}) begin
      acc_d = W'(sum - {1'b0, i_mod});
      wrap_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      wrap_q <= wrap_d;
    end
  end

  assign o_acc = acc_q;
  assign o_wrap = wrap_q;
endmodule : bmc_nco

// ==== design/bmc_pkg.sv ====
// Purpose: Types shared by the burst controller files.
// Assumes: Control word layout matches bmc_ctrl_s, high bit first.
// Notes: Origin and shape codes are the software encodings.
package bmc_pkg;
  typedef enum logic [2:0] {
    BMC_ST_IDLE = 3'b001,
    BMC_ST_COUNT = 3'b010,
    BMC_ST_GATE = 3'b100
  } bmc_state_e;
  typedef enum logic [2:0] {
    BMC_OR_INT = 3'h0,
    BMC_OR_EXT = 3'h1,
    BMC_OR_BUS = 3'h2,
    BMC_OR_IMM = 3'h3,
    BMC_OR_BPL = 3'h4
  } bmc_origin_e;
  typedef enum logic [2:0] {
    BMC_SH_SINE = 3'h0,
    BMC_SH_SQUARE = 3'h1,
    BMC_SH_TRI = 3'h2,
    BMC_SH_RAMP = 3'h3,
    BMC_SH_ARB = 3'h4
  } bmc_shape_e;
  typedef struct packed {
    logic [2:0] line;
    logic [3:0] other;
    bmc_shape_e shape;
    bmc_origin_e origin;
    logic gated;
    logic en;
  } bmc_ctrl_s;
endpackage : bmc_pkg

// ==== design/bmc_top.sv ====
// Purpose: Burst modulation controller: counted and gated bursts, limits, sync, phase.
// Assumes: Frequencies in 0.01 Hz units, phase in signed millidegrees.
// Notes: Carrier synthesis lies outside; this block gates it and supplies its phase.
`timescale 1ns/100ps
`include "bmc_map.svh"

module bmc_top
  import bmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic i_ext_trig,
  input wire logic [`BMC_NBP-1:0] i_bp_trig,
  output logic [31:0] o_rd_data,
  output logic o_wave_on,
  output logic o_sync,
  output logic [31:0] o_phase,
  output logic [4:0] o_mod_en,
  output logic o_busy
);
  bmc_ctrl_s ctrl_q, ctrl_d, w_ctrl;
  logic [31:0] freq_q, freq_d, cnt_q, cnt_d, rate_q, rate_d;
  logic [31:0] ph_q, ph_d, off_q, off_d, pts_q, pts_d, rd_q, rd_d;
  logic [31:0] fv, cv, fmx, fmn, mc;
  logic signed [31:0] pv, pn;
  logic [63:0] off64;
  logic conf_q, conf_d, conf_set, bus_trig;
  logic [`BMC_NBP:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [`BMC_NBP-1:0] bp_lvl;
  logic sel_prev_q, sel_lvl, edge_seen, applies;
  bmc_origin_e eff_org;
  bmc_state_e st_q, st_d;
  logic [31:0] cyc_q, cyc_d, car_acc, phase_d, psum;
  logic pend_q, pend_d, wave_d, sync_d, busy_d, start, restart;
  logic car_wrap, rate_wrap, rate_run, cnt_int;
  logic wave_q, sync_q, busy_q;
  logic [31:0] phase_q;

  function automatic logic [31:0] min_cnt(input logic [31:0] f);
    logic [31:0] m;
    m = `BMC_CNT_MIN;
    for (int k = 1; k < `BMC_MINCNT_TOP; k++) begin
      if (f > 32'(k) * `BMC_F_STEP) m = 32'(k + 1);
    end
    return m;
  endfunction : min_cnt

  // Pin levels: three flops, a change counts when the last two agree
  assign lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  assign bp_lvl = lvl_q[`BMC_NBP:1];

  always_comb begin
    eff_org = ctrl_q.origin;
    if (ctrl_q.origin == BMC_OR_IMM) eff_org = BMC_OR_EXT;
    if (ctrl_q.gated && ctrl_q.origin != BMC_OR_BPL) eff_org = BMC_OR_EXT;
    sel_lvl = (eff_org == BMC_OR_BPL) ? bp_lvl[ctrl_q.line] : lvl_q[0];
    edge_seen = sel_lvl && !sel_prev_q;
    applies = ctrl_q.shape != BMC_SH_TRI && ctrl_q.shape != BMC_SH_RAMP;
    cnt_int = ctrl_q.en && !ctrl_q.gated && eff_org == BMC_OR_INT;
  end

  // Register writes with limit checks
  always_comb begin
    ctrl_d = ctrl_q;
    freq_d = freq_q;
    cnt_d = cnt_q;
    rate_d = rate_q;
    ph_d = ph_q;
    off_d = off_q;
    pts_d = pts_q;
    conf_set = 1'b0;
    bus_trig = 1'b0;
    w_ctrl = bmc_ctrl_s'(i_wr_data[`BMC_CTRL_W-1:0]);
    fv = i_wr_data;
    cv = i_wr_data;
    pv = signed'(i_wr_data);
    pn = '0;
    off64 = '0;
    fmn = (ctrl_q.shape == BMC_SH_ARB) ? `BMC_F_MIN_ARB : `BMC_F_MIN;
    fmx = `BMC_F_MAX;
    if (!applies) fmx = `BMC_F_MAX_TRI;
    if (ctrl_q.shape == BMC_SH_ARB && pts_q > `BMC_PTS_12K) fmx = `BMC_F_ARB_LOW;
    else if (ctrl_q.shape == BMC_SH_ARB && pts_q > `BMC_PTS_8K) fmx = `BMC_F_ARB_MID;
    mc = min_cnt(freq_q);
    if (i_wr_stb) begin
      case (i_addr)
        `BMC_A_CTRL: begin
          ctrl_d = w_ctrl;
          // Burst wins; otherwise only the lowest requested mode survives
          if (w_ctrl.en) ctrl_d.other = '0;
          else ctrl_d.other = w_ctrl.other & (~w_ctrl.other + 4'h1);
        end
        `BMC_A_FREQ: begin
          if (fv > fmx) fv = fmx;
          if (fv < fmn) fv = fmn;
          if (applies && cnt_q != `BMC_CNT_INF && cnt_q < min_cnt(fv)) begin
            fv = cnt_q * `BMC_F_STEP;
            conf_set = 1'b1;
          end
          if (fv <= `BMC_F_LOWBAND && cnt_q != `BMC_CNT_INF &&
              cnt_q * `BMC_CU_PER_HZ > fv * `BMC_MAX_SECS) begin
            fv = (cnt_q * `BMC_CU_PER_HZ + `BMC_MAX_SECS - 32'd1) / `BMC_MAX_SECS;
            conf_set = 1'b1;
          end
          freq_d = fv;
        end
        `BMC_A_COUNT: begin
          if (cv != `BMC_CNT_INF) begin
            if (cv > `BMC_CNT_MAX) cv = `BMC_CNT_MAX;
            if (applies && cv < mc) begin
              cv = mc;
              conf_set = 1'b1;
            end
            if (freq_q <= `BMC_F_LOWBAND && cv * `BMC_CU_PER_HZ > freq_q * `BMC_MAX_SECS) begin
              cv = freq_q * `BMC_MAX_SECS / `BMC_CU_PER_HZ;
              conf_set = 1'b1;
            end
          end
          cnt_d = cv;
        end
        `BMC_A_RATE: begin
          if (fv > `BMC_R_MAX) fv = `BMC_R_MAX;
          if (fv < `BMC_R_MIN) fv = `BMC_R_MIN;
          rate_d = fv;
        end
        `BMC_A_PHASE: begin
          if (pv > `BMC_PH_MAX) pv = `BMC_PH_MAX;
          if (pv < -`BMC_PH_MAX) pv = -`BMC_PH_MAX;
          ph_d = unsigned'(pv);
          pn = (pv < 0) ? pv + `BMC_PH_MAX : pv;
          // Offset into the accumulator so zero lands on the rising crossing
          off64 = (64'(unsigned'(pn)) * 64'(`BMC_NCO_MOD)) / 64'(unsigned'(`BMC_PH_MAX));
          if (off64 >= 64'(`BMC_NCO_MOD)) off64 = off64 - 64'(`BMC_NCO_MOD);
          off_d = off64[31:0];
        end
        `BMC_A_POINTS: pts_d = i_wr_data;
        `BMC_A_TRIG: bus_trig = 1'b1;
        default: ;
      endcase
    end
    // A conflict in the clearing cycle stays set
    conf_d = conf_set |
             (conf_q & ~(i_wr_stb && i_addr == `BMC_A_STATUS && i_wr_data[0]));
  end

  always_comb begin
    rd_d = '0;
    if (i_rd_stb) begin
      case (i_addr)
        `BMC_A_CTRL: rd_d = {17'h00000, ctrl_q};
        `BMC_A_FREQ: rd_d = freq_q;
        `BMC_A_COUNT: rd_d = cnt_q;
        `BMC_A_RATE: rd_d = rate_q;
        `BMC_A_PHASE: rd_d = ph_q;
        `BMC_A_POINTS: rd_d = pts_q;
        `BMC_A_STATUS: rd_d = {28'h0000000, sel_lvl, sync_q, busy_q, conf_q};
        `BMC_A_ERR: rd_d = conf_q ? `BMC_ERR_CODE : 32'h00000000;
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= '0;
      freq_q <= `BMC_F_RST;
      cnt_q <= `BMC_CNT_MIN;
      rate_q <= `BMC_R_RST;
      ph_q <= '0;
      off_q <= '0;
      pts_q <= `BMC_PTS_RST;
      conf_q <= 1'b0;
      rd_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      sel_prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      freq_q <= freq_d;
      cnt_q <= cnt_d;
      rate_q <= rate_d;
      ph_q <= ph_d;
      off_q <= off_d;
      pts_q <= pts_d;
      conf_q <= conf_d;
      rd_q <= rd_d;
      s1_q <= {i_bp_trig, i_ext_trig};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      sel_prev_q <= sel_lvl;
    end
  end

  // Carrier phase and the internal repeat timer share one accumulator design
  assign rate_run = cnt_int;
  bmc_nco #(.W(32)) u_carrier (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_restart(restart),
    .i_inc(freq_q),
    .i_mod(`BMC_NCO_MOD),
    .o_acc(car_acc),
    .o_wrap(car_wrap)
  );
  bmc_nco #(.W(32)) u_rate (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_restart(!rate_run),
    .i_inc(rate_q),
    .i_mod(`BMC_NCO_MOD),
    .o_acc(),
    .o_wrap(rate_wrap)
  );

  // Burst sequencing
  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    pend_d = pend_q && rate_run;
    restart = 1'b0;
    start = ctrl_q.en && !ctrl_q.gated &&
            ((eff_org == BMC_OR_INT && (rate_wrap || pend_q)) ||
             ((eff_org == BMC_OR_EXT || eff_org == BMC_OR_BPL) && edge_seen) ||
             (eff_org == BMC_OR_BUS && bus_trig));
    case (st_q)
      BMC_ST_IDLE: begin
        if (ctrl_q.en && ctrl_q.gated) begin
          st_d = BMC_ST_GATE;
        end else if (start) begin
          st_d = BMC_ST_COUNT;
          cyc_d = '0;
          restart = 1'b1;
          pend_d = 1'b0;
        end
      end
      BMC_ST_COUNT: begin
        // Expiry while busy is held so the interval stretches
        if (rate_wrap && rate_run) pend_d = 1'b1;
        if (!ctrl_q.en || ctrl_q.gated) begin
          st_d = BMC_ST_IDLE;
        end else if (car_wrap) begin
          cyc_d = cyc_q + 32'd1;
          if (cnt_q != `BMC_CNT_INF && cyc_q + 32'd1 >= cnt_q) st_d = BMC_ST_IDLE;
        end
      end
      BMC_ST_GATE: begin
        if (!ctrl_q.en || !ctrl_q.gated) st_d = BMC_ST_IDLE;
        // Each gate opening begins at the rising crossing
        restart = edge_seen;
      end
      default: st_d = BMC_ST_IDLE;
    endcase
  end

  always_comb begin
    psum = car_acc + off_q;
    if (psum >= `BMC_NCO_MOD || psum < car_acc) psum = psum - `BMC_NCO_MOD;
    phase_d = (st_q == BMC_ST_COUNT) ? psum : car_acc;
    busy_d = st_d != BMC_ST_IDLE;
    case (st_d)
      BMC_ST_COUNT: begin
        wave_d = 1'b1;
        sync_d = 1'b0;
      end
      BMC_ST_GATE: begin
        wave_d = sel_lvl;
        sync_d = sel_lvl && car_acc < (`BMC_NCO_MOD >> 1);
      end
      default: begin
        // Disabled burst lets the plain carrier through
        wave_d = !ctrl_q.en;
        sync_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= BMC_ST_IDLE;
      cyc_q <= '0;
      pend_q <= 1'b0;
      wave_q <= 1'b1;
      sync_q <= 1'b1;
      busy_q <= 1'b0;
      phase_q <= '0;
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      pend_q <= pend_d;
      wave_q <= wave_d;
      sync_q <= sync_d;
      busy_q <= busy_d;
      phase_q <= phase_d;
    end
  end

  assign o_rd_data = rd_q;
  assign o_wave_on = wave_q;
  assign o_sync = sync_q;
  assign o_phase = phase_q;
  assign o_mod_en = {ctrl_q.other, ctrl_q.en};
  assign o_busy = busy_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  property p_gate_open;
    (st_q == BMC_ST_GATE && st_d == BMC_ST_GATE && eff_org == BMC_OR_EXT && lvl_q[0])
      |=> o_wave_on;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gate high but no carrier");

  property p_line_closed;
    (st_q == BMC_ST_GATE && st_d == BMC_ST_GATE && ctrl_q.origin == BMC_OR_BPL &&
     !bp_lvl[ctrl_q.line])
      |=> !o_wave_on && !o_sync;
  endproperty
  a_line_closed: assert property (p_line_closed) else $error("line false but carrier");

  property p_gate_subst;
    (ctrl_q.gated && ctrl_q.origin == BMC_OR_BUS) |-> eff_org == BMC_OR_EXT;
  endproperty
  a_gate_subst: assert property (p_gate_subst) else $error("gated origin not substituted");

  property p_freq_range;
    freq_q >= `BMC_F_MIN && freq_q <= `BMC_F_MAX;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("carrier out of range");

  property p_min_count;
    (i_wr_stb && i_addr == `BMC_A_FREQ && ctrl_q.shape == BMC_SH_SINE &&
     i_wr_data <= `BMC_F_MAX && cnt_q != `BMC_CNT_INF && cnt_q < min_cnt(i_wr_data))
      |=> freq_q == $past(cnt_q) * `BMC_F_STEP && conf_q;
  endproperty
  a_min_count: assert property (p_min_count) else $error("frequency not clamped");

  sequence s_last_cycle;
    st_q == BMC_ST_COUNT && ctrl_q.en && !ctrl_q.gated && car_wrap &&
      cnt_q != `BMC_CNT_INF && cyc_q + 32'd1 >= cnt_q;
  endsequence
  sequence s_sync_rises;
    o_sync ##1 (o_sync || o_busy);
  endsequence
  property p_burst_end;
    s_last_cycle |=> !o_busy ##0 s_sync_rises;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("sync not high after burst");

  property p_sync_low;
    (st_q == BMC_ST_COUNT && st_d == BMC_ST_COUNT) |=> !o_sync && o_busy;
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("sync high during burst");

  property p_count_range;
    cnt_q <= `BMC_CNT_MAX;
  endproperty
  a_count_range: assert property (p_count_range) else $error("count out of range");

  property p_timer_start;
    (st_q == BMC_ST_IDLE && cnt_int && rate_wrap) |=> st_q == BMC_ST_COUNT ##1 !o_sync;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer missed burst");

  property p_edge_start;
    (st_q == BMC_ST_IDLE && ctrl_q.en && !ctrl_q.gated && eff_org == BMC_OR_EXT &&
     $rose(sel_lvl)) |=> st_q == BMC_ST_COUNT;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("edge missed burst");

  property p_stretch;
    (st_q == BMC_ST_COUNT && st_d == BMC_ST_COUNT && rate_wrap && rate_run) |=> pend_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("expiry lost while busy");

  property p_one_mod;
    $onehot0(o_mod_en);
  endproperty
  a_one_mod: assert property (p_one_mod) else $error("two modulations enabled");
endmodule : bmc_top

// ==== verif/bmc_trig_src.sv ====
// Purpose: Far-side model of the front connector and backplane trigger lines.
// Assumes: Levels change by non-blocking assignment just after a rising edge.
// Notes: Idle lines sit low, as an undriven TTL trigger input would read.
`timescale 1ns/100ps
module bmc_trig_src (
  input wire logic i_ref_clk,
  output logic o_ext_trig,
  output logic [7:0] o_bp_trig
);
  initial begin
    o_ext_trig = 1'b0;
    o_bp_trig = 8'h00;
  end
  // Line -1 is the front connector, 0 to 7 a backplane line
  task put(input int line, input logic v);
    @(posedge i_ref_clk);
    if (line < 0) begin
      o_ext_trig <= v;
    end else begin
      o_bp_trig[line] <= v;
    end
  endtask : put
  // Held well past the input filter so the level is seen
  task pulse(input int line, input int n);
    put(line, 1'b1);
    repeat (n) @(posedge i_ref_clk);
    put(line, 1'b0);
  endtask : pulse
endmodule : bmc_trig_src

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the burst controller.
// Assumes: 1 MHz carrier gives exactly 25 clocks per cycle.
// Notes: Burst lengths allow one clock of slack for the pin filter.
`timescale 1ns/100ps
`include "bmc_map.svh"
module tb
  import bmc_pkg::*;
();
  logic i_ref_clk, i_arst_n, i_wr_stb, i_rd_stb, rd_seen;
  logic [7:0] i_addr;
  logic [31:0] i_wr_data, o_rd_data, o_phase, k;
  logic i_ext_trig, o_wave_on, o_sync, o_busy, last;
  logic [7:0] i_bp_trig;
  logic [4:0] o_mod_en;
  logic [31:0] exp_q[$];
  int err_total, tests_run, n;
  integer seed;
  logic [71:0] tbl [0:22] = '{
    {`BMC_A_COUNT, 32'd60000, 32'd50000},
    {`BMC_A_COUNT, 32'd1, 32'd1},
    {`BMC_A_FREQ, 32'd350000000, 32'd100000000},
    {`BMC_A_COUNT, 32'd5, 32'd5},
    {`BMC_A_FREQ, 32'd450000000, 32'd450000000},
    {`BMC_A_FREQ, 32'd600000000, 32'd500000000},
    {`BMC_A_RATE, 32'd9000000, 32'd5000000},
    {`BMC_A_RATE, 32'd0, 32'd1},
    {`BMC_A_PHASE, 32'd400000, 32'd360000},
    {`BMC_A_PHASE, 32'hFFF9E580, 32'hFFFA81C0},
    {`BMC_A_FREQ, 32'd100, 32'd100},
    {`BMC_A_COUNT, 32'd1000, 32'd500},
    {`BMC_A_FREQ, 32'd50, 32'd100},
    {`BMC_A_CTRL, 32'h40, 32'h40},
    {`BMC_A_FREQ, 32'd20000000, 32'd10000000},
    {`BMC_A_CTRL, 32'h80, 32'h80},
    {`BMC_A_POINTS, 32'd12000, 32'd12000},
    {`BMC_A_COUNT, 32'd5, 32'd5},
    {`BMC_A_FREQ, 32'd500000000, 32'd250000000},
    {`BMC_A_FREQ, 32'd5, 32'd10},
    {`BMC_A_ERR, 32'd0, `BMC_ERR_CODE},
    {`BMC_A_STATUS, 32'd1, 32'd4},
    {8'h3C, 32'd7, 32'd0}
  };

  bmc_top bmc_top_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .i_ext_trig(i_ext_trig), .i_bp_trig(i_bp_trig), .o_rd_data(o_rd_data),
    .o_wave_on(o_wave_on), .o_sync(o_sync), .o_phase(o_phase), .o_mod_en(o_mod_en),
    .o_busy(o_busy));
  bmc_trig_src bmc_trig_src_i (.i_ref_clk(i_ref_clk), .o_ext_trig(i_ext_trig),
    .o_bp_trig(i_bp_trig));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task chk1(input logic seen, input logic exp);
    check({31'd0, seen}, {31'd0, exp});
  endtask : chk1

  // Read data stand only in the cycle after the strobe
  always @(posedge i_ref_clk) begin
    if (rd_seen === 1'b1) begin
      check(o_rd_data, exp_q.pop_front());
    end
    rd_seen <= i_rd_stb;
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
  endtask : rd

  // Sample a little after the edge so the design's updates have landed
  task tick(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask : tick

  task wait_busy(input logic v);
    int w;
    w = 0;
    // Step past the edge so freshly launched outputs are read settled
    #1;
    while (o_busy !== v && w < 40) begin
      tick(1);
      w++;
    end
    if (w >= 40) begin
      err_total++;
      $display("Error at %0t: busy wait ran out", $time);
      end_sim();
    end
  endtask : wait_busy

  task meas();
    wait_busy(1'b1);
    chk1(o_sync, 1'b0);
    n = 0;
    while (o_busy === 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    chk1(o_sync, 1'b1);
    chk1(n inside {[74:76]}, 1'b1);
  endtask : meas

  function automatic logic [31:0] ctl(input logic g, input bmc_origin_e o,
                                      input logic [2:0] ln);
    bmc_ctrl_s c;
    c = '0;
    c.en = 1'b1;
    c.gated = g;
    c.origin = o;
    c.line = ln;
    return 32'(c);
  endfunction : ctl

  task end_sim();
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    seed = 32'h60BE;
    {i_arst_n, i_wr_stb, i_rd_stb} = 3'h0;
    i_addr = 8'h00;
    i_wr_data = 32'h0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    tick(1);
    check(32'({o_wave_on, o_sync, o_busy, o_mod_en}), 32'hC0);
    check(o_phase, 32'h00000000);
    rd(`BMC_A_CTRL, 32'd0);
    rd(`BMC_A_FREQ, 32'd100000);
    rd(`BMC_A_COUNT, 32'd1);
    rd(`BMC_A_RATE, 32'd10000);
    rd(`BMC_A_PHASE, 32'd0);
    rd(`BMC_A_ERR, 32'd0);
    repeat (4) begin
      k = 1 + ($unsigned($random(seed)) % 50000);
      wr(`BMC_A_COUNT, k);
      rd(`BMC_A_COUNT, k);
    end
    foreach (tbl[j]) begin
      wr(tbl[j][71:64], tbl[j][63:32]);
      rd(tbl[j][71:64], tbl[j][31:0]);
    end
    rd(`BMC_A_ERR, 32'd0);
    wr(`BMC_A_CTRL, 32'h300);
    tick(2);
    check(32'(o_mod_en), 32'h2);
    wr(`BMC_A_CTRL, ctl(1'b0, BMC_OR_EXT, 3'd0) | 32'h400);
    tick(2);
    check(32'(o_mod_en), 32'h1);
    wr(`BMC_A_FREQ, 32'd100000000);
    wr(`BMC_A_COUNT, 32'd3);
    // Trigger held high until the burst is measured, so the start is seen
    bmc_trig_src_i.put(-1, 1'b1);
    meas();
    bmc_trig_src_i.put(-1, 1'b0);
    wr(`BMC_A_TRIG, 32'd1);
    tick(10);
    chk1(o_busy, 1'b0);
    wr(`BMC_A_PHASE, 32'd90000);
    wr(`BMC_A_CTRL, ctl(1'b0, BMC_OR_BUS, 3'd0));
    wr(`BMC_A_TRIG, 32'd1);
    // A quarter turn of start phase is a quarter of the accumulator span
    tick(1);
    check(o_phase, `BMC_NCO_MOD / 32'd4);
    meas();
    wr(`BMC_A_CTRL, ctl(1'b0, BMC_OR_BPL, 3'd5));
    bmc_trig_src_i.pulse(2, 8);
    tick(10);
    chk1(o_busy, 1'b0);
    bmc_trig_src_i.put(5, 1'b1);
    meas();
    bmc_trig_src_i.put(5, 1'b0);
    wr(`BMC_A_RATE, 32'd5000000);
    wr(`BMC_A_CTRL, ctl(1'b0, BMC_OR_INT, 3'd0));
    // 500-clock timer period against a 75-clock burst
    n = 0;
    last = o_busy;
    repeat (1250) begin
      tick(1);
      if (o_busy === 1'b1 && last === 1'b0) begin
        n++;
      end
      last = o_busy;
    end
    chk1(n inside {[2:3]}, 1'b1);
    wr(`BMC_A_COUNT, 32'd50);
    rd(`BMC_A_RATE, 32'd5000000);
    // A 50-cycle burst outlasts the timer period, so expiries during it are held as one pending start
    tick(1000);
    chk1(o_busy, 1'b1);
    wr(`BMC_A_CTRL, ctl(1'b0, BMC_OR_EXT, 3'd0));
    tick(600);
    wait_busy(1'b0);
    wr(`BMC_A_COUNT, 32'd0);
    bmc_trig_src_i.pulse(-1, 8);
    wait_busy(1'b1);
    tick(300);
    chk1(o_busy, 1'b1);
    wr(`BMC_A_CTRL, 32'd0);
    tick(3);
    chk1(o_busy, 1'b0);
    wr(`BMC_A_COUNT, 32'd3);
    wr(`BMC_A_CTRL, ctl(1'b1, BMC_OR_INT, 3'd0));
    bmc_trig_src_i.put(-1, 1'b1);
    tick(10);
    chk1(o_wave_on, 1'b1);
    chk1(o_busy, 1'b1);
    n = 0;
    repeat (250) begin
      tick(1);
      n += int'(o_sync === 1'b1);
    end
    // Sync covers 13 of the 25 phase steps per cycle, the crossing included
    chk1(n == 130, 1'b1);
    chk1(o_wave_on, 1'b1);
    bmc_trig_src_i.put(-1, 1'b0);
    tick(10);
    chk1(o_wave_on, 1'b0);
    chk1(o_sync, 1'b0);
    wr(`BMC_A_CTRL, ctl(1'b1, BMC_OR_BPL, 3'd3));
    bmc_trig_src_i.put(3, 1'b1);
    tick(10);
    chk1(o_wave_on, 1'b1);
    bmc_trig_src_i.put(3, 1'b0);
    bmc_trig_src_i.put(-1, 1'b1);
    tick(10);
    chk1(o_wave_on, 1'b0);
    end_sim();
  end
endmodule : tb
